//--- hdl/ssbp_pkg.sv
// Package with register map, field layout, reset values and timing for stop and brake control.
package ssbp_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SSBP_OFS_CTRL = 8'h00;
  localparam logic [7:0] SSBP_OFS_TKEEP = 8'h04;
  localparam logic [7:0] SSBP_OFS_DEVTH = 8'h08;
  localparam logic [7:0] SSBP_OFS_OLWARN = 8'h0C;
  localparam logic [7:0] SSBP_OFS_OUTFN = 8'h10;
  localparam logic [7:0] SSBP_OFS_STATE = 8'h14;
  localparam logic [7:0] SSBP_OFS_INT_STAT = 8'h18;
  localparam logic [7:0] SSBP_OFS_INT_CLR = 8'h1C;
  localparam logic [7:0] SSBP_OFS_INT_EN = 8'h20;
  localparam logic [7:0] SSBP_OFS_SPEED = 8'h24;

  // ----------------------------------------------------------------
  // Field positions of the control and output function registers
  // ----------------------------------------------------------------
  localparam int SSBP_CTRL_STOP_LSB = 0;
  localparam int SSBP_CTRL_REGEN_LSB = 4;
  localparam int SSBP_CTRL_FLY_BIT = 8;
  localparam int SSBP_CTRL_UV_BIT = 9;
  localparam int SSBP_CTRL_SPDMODE_BIT = 10;
  localparam int SSBP_OUTFN_BRAKE_LSB = 0;
  localparam int SSBP_OUTFN_EVENT_LSB = 8;

  // ----------------------------------------------------------------
  // Setting codes, reset values, limits and event count
  // ----------------------------------------------------------------
  localparam logic [2:0] SSBP_STOP_COAST = 3'h3;
  localparam logic [2:0] SSBP_STOP_ESTOP = 3'h5;
  localparam logic [2:0] SSBP_STOP_RST = 3'h5;
  localparam logic [1:0] SSBP_REGEN_OFF = 2'h0;
  localparam logic [1:0] SSBP_REGEN_ALARM = 2'h1;
  localparam logic [1:0] SSBP_REGEN_RST = 2'h1;
  localparam logic SSBP_FLY_RST = 1'b0;
  localparam logic SSBP_UV_RST = 1'b1;
  localparam logic [4:0] SSBP_FN_BRAKE = 5'h0E;
  localparam logic [4:0] SSBP_FN_OLWARN = 5'h1B;
  localparam logic [9:0] SSBP_TKEEP_RST = 10'h000;
  localparam logic [9:0] SSBP_TKEEP_MAX = 10'h3E7;
  localparam logic [10:0] SSBP_DEVTH_RST = 11'h096;
  localparam logic [10:0] SSBP_DEVTH_MAX = 11'h3E8;
  localparam logic [6:0] SSBP_OLWARN_RST = 7'h32;
  localparam logic [6:0] SSBP_OLWARN_MIN = 7'h0A;
  localparam logic [6:0] SSBP_OLWARN_MAX = 7'h64;
  localparam int SSBP_NUM_EV = 5;

  // ----------------------------------------------------------------
  // Timing: the keep delay counts in 10 ms steps
  // ----------------------------------------------------------------
  localparam int SSBP_CLK_NS = 8;
  localparam int SSBP_TICK_NS = 10000000;
  localparam int SSBP_TICK_CYCLES = SSBP_TICK_NS / SSBP_CLK_NS;

  typedef struct packed {
    logic [2:0] stop_mode;
    logic [1:0] regen_ctrl;
    logic flying_start;
    logic uv_enable;
    logic speed_mode;
    logic [9:0] tkeep;
    logic [10:0] devth;
    logic [6:0] olwarn;
    logic [4:0] brake_fn;
    logic [4:0] event_fn;
  } ssbp_cfg_t;

endpackage : ssbp_pkg

//--- hdl/ssbp_core.sv
// Stop mode, holding brake, flying start and protection alarms behind an APB slave.
`timescale 1ns/1ns

// Summary of operation
// [RULE_01] Stop mode 3: coast while decelerating and stopped.
// [RULE_02] Stop mode 5: emergency braking, then coast.
// [RULE_03] Major alarm forces coasting deceleration.
// [RULE_04] Keep torque for programmed delay after disable.
// [RULE_05] Brake release drops when enable drops.
// [RULE_06] Brake output only with function 14 assigned.
// [RULE_07] User sets delay above brake engage time.
// [RULE_08] Regen setting: off, alarm on, alarm off.
// [RULE_09] Flying start works only in speed control.
// [RULE_10] Flying start captures speed, accelerates from it.
// [RULE_11] No speed pickup for motion at power-on.
// [RULE_12] Undervoltage alarm enable gates detection.
// [RULE_13] Deviation above threshold raises overflow alarm.
// [RULE_14] Threshold zero disables deviation overflow alarm.
// [RULE_15] Overload warning, function 27, on event pin.
// [RULE_16] User treats warning as overload advance notice.
// [RULE_17] Free-run removes all winding drive.
module ssbp_core
  import ssbp_pkg::*;
#(
  parameter int TICK_CYCLES = SSBP_TICK_CYCLES
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Drive pins and internal drive status
  input wire logic servo_enable_pin,
  input wire logic undervoltage_pin,
  input wire logic regen_overheat_pin,
  input wire logic major_alarm,
  input wire logic motor_stopped,
  input wire logic [15:0] motor_speed,
  input wire logic [23:0] position_deviation,
  input wire logic [6:0] overload_level,
  // Motor and alarm outputs
  output logic drive_enable,
  output logic torque_enable,
  output logic estop_braking,
  output logic brake_release_pin,
  output logic event_output_pin,
  output logic speed_preset_valid,
  output logic [15:0] speed_preset,
  output logic deviation_overflow_alarm,
  output logic undervoltage_alarm,
  output logic regen_overheat_alarm,
  output logic irq
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pin_meta_r;
  logic [2:0] pin_sync_r;
  wire en_s = pin_sync_r[0];
  wire uv_s = pin_sync_r[1];
  wire ovh_s = pin_sync_r[2];

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_meta_r <= 3'h0;
      pin_sync_r <= 3'h0;
    end
    else
    begin
      pin_meta_r <= {regen_overheat_pin, undervoltage_pin, servo_enable_pin};
      pin_sync_r <= pin_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  ssbp_cfg_t cfg_r;
  logic [SSBP_NUM_EV-1:0] int_stat_r;
  logic [SSBP_NUM_EV-1:0] int_en_r;
  logic en_q_r;
  logic ran_once_r;
  logic [1:0] state_code;

  // One wait state lets read data come from a flop.
  wire access = psel && penable && pready;
  wire wr = access && pwrite;
  wire hit_ctrl = paddr == SSBP_OFS_CTRL;
  wire hit_tkeep = paddr == SSBP_OFS_TKEEP;
  wire hit_devth = paddr == SSBP_OFS_DEVTH;
  wire hit_olwarn = paddr == SSBP_OFS_OLWARN;
  wire hit_outfn = paddr == SSBP_OFS_OUTFN;
  wire hit_state = paddr == SSBP_OFS_STATE;
  wire hit_istat = paddr == SSBP_OFS_INT_STAT;
  wire hit_iclr = paddr == SSBP_OFS_INT_CLR;
  wire hit_ien = paddr == SSBP_OFS_INT_EN;
  wire hit_speed = paddr == SSBP_OFS_SPEED;
  wire mapped = hit_ctrl || hit_tkeep || hit_devth || hit_olwarn || hit_outfn || hit_state
    || hit_istat || hit_iclr || hit_ien || hit_speed;
  wire [31:0] ctrl_rd = {21'h0, cfg_r.speed_mode, cfg_r.uv_enable, cfg_r.flying_start,
    2'h0, cfg_r.regen_ctrl, 1'b0, cfg_r.stop_mode};
  wire [31:0] rd_mux =
    hit_ctrl ? ctrl_rd :
    hit_tkeep ? {22'h0, cfg_r.tkeep} :
    hit_devth ? {21'h0, cfg_r.devth} :
    hit_olwarn ? {25'h0, cfg_r.olwarn} :
    hit_outfn ? {19'h0, cfg_r.event_fn, 3'h0, cfg_r.brake_fn} :
    hit_state ? {28'h0, ran_once_r, en_q_r, state_code} :
    hit_istat ? {27'h0, int_stat_r} :
    hit_ien ? {27'h0, int_en_r} :
    hit_speed ? {16'h0, speed_preset} : 32'h0;

  // Out of range values are clamped so the alarms never see an illegal level.
  wire [9:0] tkeep_wr = pwdata[9:0] > SSBP_TKEEP_MAX ? SSBP_TKEEP_MAX : pwdata[9:0];
  wire [10:0] devth_wr = pwdata[10:0] > SSBP_DEVTH_MAX ? SSBP_DEVTH_MAX : pwdata[10:0];
  wire [6:0] olw_wr = pwdata[6:0] < SSBP_OLWARN_MIN ? SSBP_OLWARN_MIN :
    pwdata[6:0] > SSBP_OLWARN_MAX ? SSBP_OLWARN_MAX : pwdata[6:0];

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      prdata <= (psel && !pwrite) ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_r <= '{stop_mode: SSBP_STOP_RST, regen_ctrl: SSBP_REGEN_RST,
        flying_start: SSBP_FLY_RST, uv_enable: SSBP_UV_RST, speed_mode: 1'b0,
        tkeep: SSBP_TKEEP_RST, devth: SSBP_DEVTH_RST, olwarn: SSBP_OLWARN_RST,
        brake_fn: 5'h00, event_fn: 5'h00};
      int_en_r <= '0;
    end
    else if (wr)
    begin
      if (hit_ctrl)
      begin
        cfg_r.stop_mode <= pwdata[SSBP_CTRL_STOP_LSB +: 3];
        cfg_r.regen_ctrl <= pwdata[SSBP_CTRL_REGEN_LSB +: 2];
        cfg_r.flying_start <= pwdata[SSBP_CTRL_FLY_BIT];
        cfg_r.uv_enable <= pwdata[SSBP_CTRL_UV_BIT];
        cfg_r.speed_mode <= pwdata[SSBP_CTRL_SPDMODE_BIT];
      end
      if (hit_tkeep)
        cfg_r.tkeep <= tkeep_wr;
      if (hit_devth)
        cfg_r.devth <= devth_wr;
      if (hit_olwarn)
        cfg_r.olwarn <= olw_wr;
      if (hit_outfn)
      begin
        cfg_r.brake_fn <= pwdata[SSBP_OUTFN_BRAKE_LSB +: 5];
        cfg_r.event_fn <= pwdata[SSBP_OUTFN_EVENT_LSB +: 5];
      end
      if (hit_ien)
        int_en_r <= pwdata[SSBP_NUM_EV-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Stop sequencer
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_FREE, ST_RUN, ST_HOLD, ST_DECEL} ssbp_state_t;
  ssbp_state_t st_r;
  ssbp_state_t st_nxt;
  logic [20:0] pre_r;
  logic [9:0] hold_r;
  assign state_code = st_r;

  wire tick = pre_r == 21'(TICK_CYCLES - 1);
  wire hold_done = hold_r >= cfg_r.tkeep;
  wire en_rise = en_s && !en_q_r;
  // Pickup only after the drive itself has run and let the motor coast.
  wire fly_go = en_rise && st_r == ST_FREE && cfg_r.flying_start && cfg_r.speed_mode
    && ran_once_r && !major_alarm; // [RULE_09] [RULE_11]

  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      ST_FREE:
        if (en_rise && !major_alarm)
          st_nxt = ST_RUN;
      ST_RUN:
        if (major_alarm)
          st_nxt = ST_FREE; // [RULE_03]
        else if (!en_s)
          st_nxt = ST_HOLD; // [RULE_04]
      ST_HOLD:
        if (major_alarm)
          st_nxt = ST_FREE; // [RULE_03]
        else if (hold_done && cfg_r.stop_mode == SSBP_STOP_ESTOP)
          st_nxt = ST_DECEL; // [RULE_02]
        else if (hold_done)
          st_nxt = ST_FREE; // [RULE_01]
      ST_DECEL:
        if (major_alarm || motor_stopped)
          st_nxt = ST_FREE; // [RULE_02] [RULE_03]
      default:
        st_nxt = ST_FREE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_r <= ST_FREE;
      en_q_r <= 1'b0;
      ran_once_r <= 1'b0;
      pre_r <= 21'h0;
      hold_r <= 10'h0;
    end
    else
    begin
      st_r <= st_nxt;
      en_q_r <= en_s;
      if (st_r == ST_RUN)
        ran_once_r <= 1'b1; // [RULE_11]
      pre_r <= (st_r != ST_HOLD || tick) ? 21'h0 : pre_r + 21'h1;
      if (st_r != ST_HOLD)
        hold_r <= 10'h0;
      else if (tick && !hold_done)
        hold_r <= hold_r + 10'h1; // [RULE_04]
    end
  end

  // ----------------------------------------------------------------
  // Motor, brake and alarm outputs
  // ----------------------------------------------------------------
  wire brake_ok = cfg_r.brake_fn == SSBP_FN_BRAKE;
  wire olw_ok = cfg_r.event_fn == SSBP_FN_OLWARN;
  wire dev_over = cfg_r.devth != 11'h0
    && position_deviation > {13'h0, cfg_r.devth}; // [RULE_13] [RULE_14]
  wire olw_hit = olw_ok && overload_level >= cfg_r.olwarn; // [RULE_15]
  wire uv_hit = cfg_r.uv_enable && uv_s; // [RULE_12]
  wire regen_hit = cfg_r.regen_ctrl == SSBP_REGEN_ALARM && ovh_s; // [RULE_08]
  wire free_nxt = st_nxt == ST_FREE;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      drive_enable <= 1'b0;
      torque_enable <= 1'b0;
      estop_braking <= 1'b0;
      brake_release_pin <= 1'b0;
      event_output_pin <= 1'b0;
      speed_preset_valid <= 1'b0;
      speed_preset <= 16'h0;
      deviation_overflow_alarm <= 1'b0;
      undervoltage_alarm <= 1'b0;
      regen_overheat_alarm <= 1'b0;
    end
    else
    begin
      drive_enable <= !free_nxt; // [RULE_17]
      torque_enable <= st_nxt == ST_RUN || st_nxt == ST_HOLD; // [RULE_04]
      estop_braking <= st_nxt == ST_DECEL; // [RULE_02]
      brake_release_pin <= brake_ok && en_s && st_nxt == ST_RUN; // [RULE_05] [RULE_06]
      event_output_pin <= olw_hit; // [RULE_15]
      speed_preset_valid <= fly_go; // [RULE_10]
      if (fly_go)
        speed_preset <= motor_speed; // [RULE_10]
      else if (en_rise && st_r == ST_FREE)
        speed_preset <= 16'h0;
      deviation_overflow_alarm <= dev_over; // [RULE_13]
      undervoltage_alarm <= uv_hit; // [RULE_12]
      regen_overheat_alarm <= regen_hit; // [RULE_08]
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status, clear and enable
  // ----------------------------------------------------------------
  wire [SSBP_NUM_EV-1:0] ev = {st_r != ST_FREE && free_nxt, regen_hit, uv_hit, olw_hit, dev_over};
  wire [SSBP_NUM_EV-1:0] clr = (wr && hit_iclr) ? pwdata[SSBP_NUM_EV-1:0] : '0;

  // A new event in the clear cycle survives the clear.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      int_stat_r <= '0;
      irq <= 1'b0;
    end
    else
    begin
      int_stat_r <= (int_stat_r & ~clr) | ev;
      irq <= |(((int_stat_r & ~clr) | ev) & int_en_r);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  coast_on_alarm_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_03]
    major_alarm |=> !torque_enable && !estop_braking)
    else $error("major alarm did not force coasting");

  brake_drop_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_05]
    $fell(en_s) |=> !brake_release_pin)
    else $error("brake release stayed high after enable fell");

  brake_function_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_06]
    brake_release_pin |-> $past(brake_ok))
    else $error("brake output without function 14");

  hold_torque_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_04]
    (st_r == ST_RUN && !en_s && !major_alarm && cfg_r.tkeep != 10'h0)
      |=> torque_enable && !brake_release_pin)
    else $error("torque not held after enable fell");

  estop_mode_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_01]
    estop_braking |-> $past(cfg_r.stop_mode) == SSBP_STOP_ESTOP)
    else $error("emergency braking outside stop mode 5");

  free_at_stop_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_02]
    (st_r == ST_DECEL && motor_stopped) |=> !drive_enable ##1 (!drive_enable || $past(en_rise)))
    else $error("drive not released at standstill");

  fly_pickup_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_10]
    speed_preset_valid |-> speed_preset == $past(motor_speed)
      && $past(cfg_r.speed_mode) && $past(ran_once_r))
    else $error("flying start pickup value or condition wrong");

  uv_gate_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_12]
    undervoltage_alarm |-> $past(cfg_r.uv_enable))
    else $error("undervoltage alarm while detection disabled");

  dev_zero_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_14]
    deviation_overflow_alarm |-> $past(cfg_r.devth) != 11'h0)
    else $error("deviation alarm with zero threshold");

  olwarn_pin_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_15]
    event_output_pin |-> $past(cfg_r.event_fn) == SSBP_FN_OLWARN
      && $past(overload_level) >= $past(cfg_r.olwarn))
    else $error("overload warning without function 27 or level");

  regen_gate_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_08]
    regen_overheat_alarm |-> $past(cfg_r.regen_ctrl) == SSBP_REGEN_ALARM)
    else $error("regen alarm outside setting 1");

  free_no_drive_a: assert property (@(posedge clk) disable iff (!reset_n) // [RULE_17]
    st_r == ST_FREE |-> !torque_enable && !estop_braking)
    else $error("drive active during free-run");

endmodule : ssbp_core

//--- verification/ssbp_motor_model.sv
// Behavioural motor with holding brake and speed encoder for the stop and brake bench.
`timescale 1ns/1ns
module ssbp_motor_model
#(
  parameter logic [15:0] TOP_SPEED = 16'h0200,
  parameter logic [3:0] ENGAGE_CYCLES = 4'h6
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Drive side
  input wire logic torque_enable,
  input wire logic estop_braking,
  input wire logic brake_release_pin,
  // Bench controls
  input wire logic kick,
  input wire logic [15:0] kick_speed,
  // Encoder and brake side
  output logic motor_stopped,
  output logic [15:0] motor_speed,
  output logic brake_gripped
);
  logic [5:0] coast_r;
  logic [3:0] engage_r;

  // The brake needs a few cycles after release drops before it really grips.
  assign brake_gripped = engage_r == ENGAGE_CYCLES;
  assign motor_stopped = motor_speed == 16'h0000;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      engage_r <= 4'h0;
    else if (brake_release_pin)
      engage_r <= 4'h0;
    else if (engage_r != ENGAGE_CYCLES)
      engage_r <= engage_r + 4'h1;
  end

  // Coasting loses speed slowly, so a pickup sees a steady value for many cycles.
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      motor_speed <= 16'h0000;
      coast_r <= 6'h00;
    end
    else if (kick)
      motor_speed <= kick_speed;
    else if (torque_enable && motor_speed < TOP_SPEED)
      motor_speed <= motor_speed + 16'h0001;
    else if (estop_braking)
      motor_speed <= (motor_speed > 16'h0004) ? motor_speed - 16'h0004 : 16'h0000;
    else if (!torque_enable && !motor_stopped)
    begin
      coast_r <= coast_r + 6'h01;
      if (coast_r == 6'h3F)
        motor_speed <= motor_speed - 16'h0001;
    end
  end
endmodule : ssbp_motor_model

//--- verification/servo_stop_brake_protection_bench.sv
// Self-checking bench for the stop, brake and protection block.
`timescale 1ns/1ns
module servo_stop_brake_protection_bench;
  import ssbp_pkg::*;
  logic clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic sen, uvp, rop, major, kick, stopped, drv, trq, estop, brk, evt, spv, dova, uva, rga, irq;
  logic gripped;
  logic [15:0] kick_speed, mspeed, spreset, pick_speed, prev_speed;
  logic [23:0] dev;
  logic [6:0] oll;
  int errors = 0;
  int num_checks = 0;
  int picks = 0;

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  ssbp_core #(.TICK_CYCLES(4)) DUT (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .servo_enable_pin(sen), .undervoltage_pin(uvp),
    .regen_overheat_pin(rop), .major_alarm(major), .motor_stopped(stopped),
    .motor_speed(mspeed), .position_deviation(dev), .overload_level(oll),
    .drive_enable(drv), .torque_enable(trq), .estop_braking(estop),
    .brake_release_pin(brk), .event_output_pin(evt), .speed_preset_valid(spv),
    .speed_preset(spreset), .deviation_overflow_alarm(dova), .undervoltage_alarm(uva),
    .regen_overheat_alarm(rga), .irq(irq));

  ssbp_motor_model motor (.clk(clk), .reset_n(reset_n), .torque_enable(trq),
    .estop_braking(estop), .brake_release_pin(brk), .kick(kick), .kick_speed(kick_speed),
    .motor_stopped(stopped), .motor_speed(mspeed), .brake_gripped(gripped));

  // The pickup pulse trails the edge at which the speed was taken, so keep last cycle's speed.
  always @(posedge clk)
  begin
    prev_speed <= mspeed;
    if (spv === 1'b1)
    begin
      picks <= picks + 1;
      pick_speed <= prev_speed;
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task give_verdict;
    $display("checks=%0d errors=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  // Entered just after a rising edge; leaves one idle cycle so psel is never set twice at once.
  task apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(q, exp);
  endtask : rd

  task wait_cycles(input int n);
    repeat (n) @(posedge clk);
  endtask : wait_cycles

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task s_reset_values;
    rd(SSBP_OFS_CTRL, 32'h0000_0215);
    rd(SSBP_OFS_TKEEP, 32'h0);
    rd(SSBP_OFS_DEVTH, 32'h0000_0096);
    rd(SSBP_OFS_OLWARN, 32'h0000_0032);
    apb(1'b0, 8'h40, 32'h0);
    check({q[30:0], err}, 32'h1);
  endtask : s_reset_values

  task s_flying;
    apb(1'b1, SSBP_OFS_CTRL, 32'h0000_0713);
    kick <= 1'b1;
    kick_speed <= 16'h0100;
    wait_cycles(1);
    kick <= 1'b0;
    sen <= 1'b1;
    wait_cycles(8);
    check(picks, 0);
    check(drv, 1'b1);
    wait_cycles(600);
    sen <= 1'b0;
    wait_cycles(20);
    check({drv, trq}, 2'b00);
    sen <= 1'b1;
    wait_cycles(8);
    check(picks, 1);
    check(spreset, pick_speed);
    check(pick_speed > 16'h0100, 1'b1);
    sen <= 1'b0;
    wait_cycles(20);
    apb(1'b1, SSBP_OFS_CTRL, 32'h0000_0313);
    sen <= 1'b1;
    wait_cycles(8);
    check(picks, 1);
    check(spreset, 16'h0);
    sen <= 1'b0;
    wait_cycles(8);
  endtask : s_flying

  task s_brake;
    int n;
    n = 0;
    apb(1'b1, SSBP_OFS_CTRL, 32'h0000_0215);
    // Twelve cycles of torque outlast the six that the brake needs to grip.
    apb(1'b1, SSBP_OFS_TKEEP, 32'h3);
    apb(1'b1, SSBP_OFS_OUTFN, 32'h0);
    sen <= 1'b1;
    wait_cycles(8);
    check(brk, 1'b0);
    apb(1'b1, SSBP_OFS_OUTFN, 32'h0000_000E);
    wait_cycles(4);
    check({brk, trq}, 2'b11);
    wait_cycles(600);
    sen <= 1'b0;
    wait_cycles(4);
    check({brk, trq}, 2'b01);
    while (trq === 1'b1 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    check(n >= 6 && n <= 14, 1'b1);
    check({estop, gripped}, 2'b11);
    n = 0;
    while (drv !== 1'b0 && n < 500)
    begin
      @(posedge clk);
      n++;
    end
    check({stopped, estop, trq}, 3'b100);
    apb(1'b1, SSBP_OFS_TKEEP, 32'h0000_03FF);
    rd(SSBP_OFS_TKEEP, 32'h0000_03E7);
    apb(1'b1, SSBP_OFS_TKEEP, 32'h0);
  endtask : s_brake

  task s_coast_major;
    apb(1'b1, SSBP_OFS_CTRL, 32'h0000_0213);
    sen <= 1'b1;
    wait_cycles(200);
    sen <= 1'b0;
    wait_cycles(8);
    check({drv, estop, stopped}, 3'b000);
    apb(1'b1, SSBP_OFS_CTRL, 32'h0000_0215);
    sen <= 1'b1;
    wait_cycles(200);
    major <= 1'b1;
    wait_cycles(2);
    check({drv, estop}, 2'b00);
    sen <= 1'b0;
    wait_cycles(6);
    sen <= 1'b1;
    wait_cycles(8);
    check(drv, 1'b0);
    major <= 1'b0;
    sen <= 1'b0;
    wait_cycles(8);
  endtask : s_coast_major

  task s_deviation_irq;
    apb(1'b1, SSBP_OFS_INT_CLR, 32'h1F);
    apb(1'b1, SSBP_OFS_INT_EN, 32'h1);
    dev <= 24'd151;
    wait_cycles(4);
    check({dova, irq}, 2'b11);
    dev <= 24'd150;
    wait_cycles(4);
    check({dova, irq}, 2'b01);
    apb(1'b1, SSBP_OFS_INT_EN, 32'h0);
    wait_cycles(1);
    check(irq, 1'b0);
    apb(1'b1, SSBP_OFS_INT_EN, 32'h1);
    wait_cycles(1);
    check(irq, 1'b1);
    apb(1'b1, SSBP_OFS_INT_CLR, 32'h1);
    apb(1'b0, SSBP_OFS_INT_STAT, 32'h0);
    check({irq, q[0]}, 2'b00);
    apb(1'b1, SSBP_OFS_DEVTH, 32'h0);
    dev <= 24'hFFFFFF;
    wait_cycles(4);
    check(dova, 1'b0);
    apb(1'b1, SSBP_OFS_DEVTH, 32'h0000_03E9);
    rd(SSBP_OFS_DEVTH, 32'h0000_03E8);
    wait_cycles(2);
    check(dova, 1'b1);
    dev <= 24'h0;
  endtask : s_deviation_irq

  task s_overload;
    int w[6] = '{50, 50, 100, 100, 10, 10};
    int lv[6] = '{49, 50, 99, 100, 10, 9};
    logic ex[6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    // The warning level sits below the alarm, giving early notice of overload.
    apb(1'b1, SSBP_OFS_OUTFN, 32'h0000_1B00);
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b1, SSBP_OFS_OLWARN, w[i]);
      oll <= lv[i][6:0];
      wait_cycles(4);
      check(evt, ex[i]);
    end
    apb(1'b1, SSBP_OFS_OLWARN, 32'h5);
    rd(SSBP_OFS_OLWARN, 32'h0000_000A);
    apb(1'b1, SSBP_OFS_OUTFN, 32'h0);
    oll <= 7'h64;
    wait_cycles(4);
    check(evt, 1'b0);
    oll <= 7'h00;
  endtask : s_overload

  task s_uv_regen;
    uvp <= 1'b1;
    wait_cycles(6);
    check(uva, 1'b1);
    apb(1'b1, SSBP_OFS_CTRL, 32'h0000_0015);
    wait_cycles(4);
    check(uva, 1'b0);
    uvp <= 1'b0;
    rop <= 1'b1;
    for (int m = 0; m < 3; m++)
    begin
      apb(1'b1, SSBP_OFS_CTRL, 32'h0000_0205 | (m << 4));
      wait_cycles(6);
      check(rga, m == 1);
    end
    rop <= 1'b0;
  endtask : s_uv_regen

  initial
  begin
    {reset_n, psel, penable, pwrite, sen, uvp, rop, major, kick} = 9'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    kick_speed = 16'h0;
    dev = 24'h0;
    oll = 7'h00;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    s_reset_values;
    s_flying;
    s_brake;
    s_coast_major;
    s_deviation_irq;
    s_overload;
    s_uv_regen;
    give_verdict;
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    errors++;
    give_verdict;
  end
endmodule : servo_stop_brake_protection_bench
